// file: include/window_base_pkg.sv
// Package with register map, field layout and reset values of the window base registers
// How it works
// - Window 1 base bits 31:24, 16 MB
// - Window 1 prefetch flag reads one
// - Memory type bits 2:1 read zero
// - Memory space flag bit 0 reads zero
// - No dual-address cycles, upper base unused
// - Window 2 base bits 31:20, 1 MB
// - Window 2 prefetch flag reads zero
// - I/O base bits 31:8, 256 bytes
// - I/O space flag bit 0 reads one
// - Writable base fields reset to zero
// - Agent mode blocks internal register access
// - Config offsets 0x18, 0x20, 0x24
// - Subsystem ids read-only, loadable from EEPROM
package window_base_pkg;

  // ****************************************
  // Internal register offsets
  // ****************************************
  localparam logic [15:0] MEM1_LOW_OFFSET   = 16'hd018;
  localparam logic [15:0] MEM1_HIGH_OFFSET  = 16'hd01c;
  localparam logic [15:0] MEM2_OFFSET       = 16'hd020;
  localparam logic [15:0] IO_OFFSET         = 16'hd024;
  localparam logic [15:0] SUBSYS_OFFSET     = 16'hd02c;

  // ****************************************
  // Configuration header offsets
  // ****************************************
  localparam logic [7:0]  CFG_MEM1_LOW      = 8'h18;
  localparam logic [7:0]  CFG_MEM1_HIGH     = 8'h1c;
  localparam logic [7:0]  CFG_MEM2          = 8'h20;
  localparam logic [7:0]  CFG_IO            = 8'h24;
  localparam logic [7:0]  CFG_SUBSYS        = 8'h2c;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int          MEM1_BASE_LSB     = 24;
  localparam int          MEM2_BASE_LSB     = 20;
  localparam int          IO_BASE_LSB       = 8;
  localparam int          PREFETCH_BIT      = 3;
  localparam int          SPACE_BIT         = 0;
  localparam int          SUBSYS_IDENT_LSB  = 16;

  // ****************************************
  // Fixed and reset values
  // ****************************************
  localparam logic        MEM1_PREFETCH     = 1'b1;
  localparam logic        MEM2_PREFETCH     = 1'b0;
  localparam logic [1:0]  MEM_TYPE_32       = 2'h0;
  localparam logic        MEMORY_SPACE_FLAG = 1'b0;
  localparam logic        IO_SPACE_FLAG     = 1'b1;
  localparam logic [31:0] BASE_RESET        = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;

  // Decode target of an access
  typedef enum logic [2:0] {
    REG_MEM1_LOW,
    REG_MEM1_HIGH,
    REG_MEM2,
    REG_IO,
    REG_SUBSYS,
    REG_NONE
  } reg_sel_type;

endpackage

// file: hdl/window_match.sv
// Address comparator for one fixed-size target window
`timescale 1ns/100ps
module window_match #(
  parameter int BASE_LSB = 24
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_base,
  input  wire logic        i_space_enable,
  input  wire logic        i_valid,
  output logic             o_hit
);

  // Window size must leave at least one base bit; refused while elaborating
  if (BASE_LSB < 1 || BASE_LSB > 31) begin : g_bad_lsb
    $error("BASE_LSB out of range");
  end

  // Registered hit; only upper bits compare since the size is fixed
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_hit <= 1'b0;
    end else begin
      o_hit <= i_valid && i_space_enable && (i_addr[31:BASE_LSB] == i_base[31:BASE_LSB]);
    end
  end

endmodule

// file: hdl/window_base_regs.sv
// Window base address registers with subsystem identity and target window decode
`timescale 1ns/100ps
module window_base_regs
  import window_base_pkg::*;
#(
  parameter logic [15:0] SUBSYS_IDENT_DEFAULT  = 16'h0000, // Arbitrary neutral value
  parameter logic [15:0] SUBSYS_VENDOR_DEFAULT = 16'h0000  // Arbitrary neutral value
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Configuration access from the PCI host
  input  wire logic        i_cfg_write,
  input  wire logic        i_cfg_read,
  input  wire logic [7:0]  i_cfg_offset,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic [3:0]  i_cfg_byte_en,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // Internal register path
  input  wire logic        i_int_write,
  input  wire logic        i_int_read,
  input  wire logic [15:0] i_int_addr,
  input  wire logic [31:0] i_int_wdata,
  input  wire logic [3:0]  i_int_byte_en,
  output logic [31:0]      o_int_rdata,
  output logic             o_int_rvalid,
  output logic             o_int_blocked,
  input  wire logic        i_agent_mode,
  // Subsystem identity load from the serial EEPROM
  input  wire logic        i_eeprom_load,
  input  wire logic [31:0] i_eeprom_data,
  // Target decode
  input  wire logic        i_memory_enable,
  input  wire logic        i_io_enable,
  input  wire logic        i_addr_valid,
  input  wire logic        i_addr_is_io,
  input  wire logic [31:0] i_addr,
  output logic             o_mem1_hit,
  output logic             o_mem2_hit,
  output logic             o_io_hit,
  output logic [31:0]      o_mem1_base,
  output logic [31:0]      o_mem2_base,
  output logic [31:0]      o_io_base
);

  // ****************************************
  // Storage
  // ****************************************
  logic [31:MEM1_BASE_LSB] mem1_base;    // Window 1 base field
  logic [31:MEM2_BASE_LSB] mem2_base;    // Window 2 base field
  logic [31:IO_BASE_LSB]   io_base;      // I/O window base field
  logic [31:0]             subsys_word;  // Subsystem identity word

  // ****************************************
  // Access selection
  // ****************************************
  reg_sel_type cfg_sel;        // Target of configuration access
  reg_sel_type int_sel;        // Target of internal access
  logic        int_allowed;    // Internal path open
  reg_sel_type wr_sel;         // Merged write target
  logic [31:0] wr_data;        // Merged write data
  logic [3:0]  wr_en;          // Merged byte enables
  logic        wr_go;          // A write happens this cycle
  logic [31:0] next_mem1_word; // Window 1 word after write
  logic [31:0] next_mem2_word; // Window 2 word after write
  logic [31:0] next_io_word;   // I/O word after write
  logic [31:0] mem1_word;      // Full window 1 word
  logic [31:0] mem2_word;      // Full window 2 word
  logic [31:0] io_word;        // Full I/O word

  // Configuration header offset decode
  always_comb begin
    unique case (i_cfg_offset)
      CFG_MEM1_LOW:  cfg_sel = REG_MEM1_LOW;
      CFG_MEM1_HIGH: cfg_sel = REG_MEM1_HIGH;
      CFG_MEM2:      cfg_sel = REG_MEM2;
      CFG_IO:        cfg_sel = REG_IO;
      CFG_SUBSYS:    cfg_sel = REG_SUBSYS;
      default:       cfg_sel = REG_NONE;
    endcase
  end

  // Internal address decode
  always_comb begin
    unique case (i_int_addr)
      MEM1_LOW_OFFSET:  int_sel = REG_MEM1_LOW;
      MEM1_HIGH_OFFSET: int_sel = REG_MEM1_HIGH;
      MEM2_OFFSET:      int_sel = REG_MEM2;
      IO_OFFSET:        int_sel = REG_IO;
      SUBSYS_OFFSET:    int_sel = REG_SUBSYS;
      default:          int_sel = REG_NONE;
    endcase
  end

  // Agent mode shuts the internal path entirely
  assign int_allowed = !i_agent_mode;

  // Configuration write takes priority; an internal write in the same cycle is dropped
  always_comb begin
    if (i_cfg_write) begin
      wr_go   = 1'b1;
      wr_sel  = cfg_sel;
      wr_data = i_cfg_wdata;
      wr_en   = i_cfg_byte_en;
    end else begin
      wr_go   = i_int_write && int_allowed;
      wr_sel  = int_sel;
      wr_data = i_int_wdata;
      wr_en   = i_int_byte_en;
    end
  end

  // Byte-lane merge of a write into the current register words
  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [3:0]  lanes);
    logic [31:0] result;
    result = old_word;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        result[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return result;
  endfunction

  // Merge against the live words, not the delayed outputs, so back-to-back writes keep every lane
  assign next_mem1_word = merge(mem1_word, wr_data, wr_en);
  assign next_mem2_word = merge(mem2_word, wr_data, wr_en);
  assign next_io_word   = merge(io_word, wr_data, wr_en);

  // ****************************************
  // Base field registers
  // ****************************************

  // Window 1 base; only the upper byte is kept, the rest is fixed
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mem1_base <= BASE_RESET[31:MEM1_BASE_LSB];
    end else if (wr_go && wr_sel == REG_MEM1_LOW) begin
      mem1_base <= next_mem1_word[31:MEM1_BASE_LSB];
    end
  end

  // Window 2 base
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mem2_base <= BASE_RESET[31:MEM2_BASE_LSB];
    end else if (wr_go && wr_sel == REG_MEM2) begin
      mem2_base <= next_mem2_word[31:MEM2_BASE_LSB];
    end
  end

  // I/O window base
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      io_base <= BASE_RESET[31:IO_BASE_LSB];
    end else if (wr_go && wr_sel == REG_IO) begin
      io_base <= next_io_word[31:IO_BASE_LSB];
    end
  end

  // Subsystem identity: software writes ignored, EEPROM load replaces it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      subsys_word <= {SUBSYS_IDENT_DEFAULT, SUBSYS_VENDOR_DEFAULT};
    end else if (i_eeprom_load) begin
      subsys_word <= i_eeprom_data;
    end
  end

  // ****************************************
  // Read-back words
  // ****************************************

  // Fixed flags and zeroed reserved bits around each base field
  always_comb begin
    mem1_word                          = ZERO_WORD;
    mem1_word[31:MEM1_BASE_LSB]        = mem1_base;
    mem1_word[PREFETCH_BIT]            = MEM1_PREFETCH;
    mem1_word[PREFETCH_BIT-1:SPACE_BIT+1] = MEM_TYPE_32;
    mem1_word[SPACE_BIT]               = MEMORY_SPACE_FLAG;
    mem2_word                          = ZERO_WORD;
    mem2_word[31:MEM2_BASE_LSB]        = mem2_base;
    mem2_word[PREFETCH_BIT]            = MEM2_PREFETCH;
    mem2_word[PREFETCH_BIT-1:SPACE_BIT+1] = MEM_TYPE_32;
    mem2_word[SPACE_BIT]               = MEMORY_SPACE_FLAG;
    io_word                            = ZERO_WORD;
    io_word[31:IO_BASE_LSB]            = io_base;
    io_word[SPACE_BIT]                 = IO_SPACE_FLAG;
  end

  // Word selected by a decode result; upper window 1 word always reads zero
  function automatic logic [31:0] pick(input reg_sel_type sel,
                                       input logic [31:0] w1,
                                       input logic [31:0] w2,
                                       input logic [31:0] wi,
                                       input logic [31:0] ws);
    logic [31:0] result;
    result = ZERO_WORD;
    unique case (sel)
      REG_MEM1_LOW:  result = w1;
      REG_MEM1_HIGH: result = ZERO_WORD;
      REG_MEM2:      result = w2;
      REG_IO:        result = wi;
      REG_SUBSYS:    result = ws;
      REG_NONE:      result = ZERO_WORD;
    endcase
    return result;
  endfunction

  // Configuration read answer, one cycle after the request
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cfg_rdata  <= ZERO_WORD;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_read;
      if (i_cfg_read) begin
        o_cfg_rdata <= pick(cfg_sel, mem1_word, mem2_word, io_word, subsys_word);
      end
    end
  end

  // Internal read answer; in agent mode it returns zero and flags the block
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_int_rdata   <= ZERO_WORD;
      o_int_rvalid  <= 1'b0;
      o_int_blocked <= 1'b0;
    end else begin
      o_int_rvalid  <= i_int_read;
      o_int_blocked <= (i_int_read || i_int_write) && !int_allowed;
      if (i_int_read) begin
        o_int_rdata <= int_allowed ? pick(int_sel, mem1_word, mem2_word, io_word, subsys_word)
                                   : ZERO_WORD;
      end
    end
  end

  // Programmed bases for the rest of the controller
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_mem1_base <= BASE_RESET;
      o_mem2_base <= BASE_RESET;
      o_io_base   <= BASE_RESET;
    end else begin
      o_mem1_base <= mem1_word;
      o_mem2_base <= mem2_word;
      o_io_base   <= io_word;
    end
  end

  // ****************************************
  // Target window decode
  // ****************************************
  // Compare against the live base so a new base takes effect on the next address
  // Dual-address cycles are never decoded: only a 32-bit address is compared
  window_match #(.BASE_LSB(MEM1_BASE_LSB)) u_mem1_match (
    .i_clk          (i_clk),
    .i_reset        (i_reset),
    .i_addr         (i_addr),
    .i_base         (mem1_word),
    .i_space_enable (i_memory_enable),
    .i_valid        (i_addr_valid && !i_addr_is_io),
    .o_hit          (o_mem1_hit)
  );

  window_match #(.BASE_LSB(MEM2_BASE_LSB)) u_mem2_match (
    .i_clk          (i_clk),
    .i_reset        (i_reset),
    .i_addr         (i_addr),
    .i_base         (mem2_word),
    .i_space_enable (i_memory_enable),
    .i_valid        (i_addr_valid && !i_addr_is_io),
    .o_hit          (o_mem2_hit)
  );

  window_match #(.BASE_LSB(IO_BASE_LSB)) u_io_match (
    .i_clk          (i_clk),
    .i_reset        (i_reset),
    .i_addr         (i_addr),
    .i_base         (io_word),
    .i_space_enable (i_io_enable),
    .i_valid        (i_addr_valid && i_addr_is_io),
    .o_hit          (o_io_hit)
  );

endmodule

// file: verification/window_base_regs_asserts.sv
// Checker for the window base register ports
`timescale 1ns/100ps
module window_base_regs_asserts (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_cfg_read,
  input wire logic [7:0]  i_cfg_offset,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_cfg_rvalid,
  input wire logic        i_int_read,
  input wire logic        i_int_write,
  input wire logic        i_agent_mode,
  input wire logic [31:0] o_int_rdata,
  input wire logic        o_int_rvalid,
  input wire logic        o_int_blocked,
  input wire logic        i_addr_valid,
  input wire logic        i_addr_is_io,
  input wire logic        i_memory_enable,
  input wire logic        i_io_enable,
  input wire logic        o_mem1_hit,
  input wire logic        o_mem2_hit,
  input wire logic        o_io_hit,
  input wire logic [31:0] o_mem1_base,
  input wire logic [31:0] o_mem2_base,
  input wire logic [31:0] o_io_base
);
  // ****************************************
  // Properties
  // ****************************************
  // Base words read zero while reset holds, flags only show one edge later
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_RESET_ZERO: assert property ($past(i_reset) |->
    o_mem1_base == 32'h0000_0000 && o_mem2_base == 32'h0000_0000 && o_io_base == 32'h0000_0000)
    else $error("base word not cleared by reset");
  AST_MEM1_FIXED: assert property (!$past(i_reset) |->
    o_mem1_base[23:0] == 24'h00_0008)
    else $error("window 1 fixed bits wrong");
  AST_MEM2_FIXED: assert property (!$past(i_reset) |-> o_mem2_base[19:0] == 20'h0_0000)
    else $error("window 2 fixed bits wrong");
  AST_IO_FIXED: assert property (!$past(i_reset) |-> o_io_base[7:0] == 8'h01)
    else $error("io fixed bits wrong");
  AST_CFG_ANSWER: assert property (!$past(i_reset) |-> o_cfg_rvalid == $past(i_cfg_read))
    else $error("config read answer misplaced");
  AST_UPPER_ZERO: assert property (i_cfg_read && i_cfg_offset == 8'h1c |=> o_cfg_rdata == 32'h0000_0000)
    else $error("upper base read not zero");
  AST_BLOCKED: assert property (i_agent_mode && (i_int_read || i_int_write) |=> o_int_blocked)
    else $error("agent access not blocked");
  AST_BLOCK_DATA: assert property (i_agent_mode && i_int_read |=>
    o_int_rvalid && o_int_rdata == 32'h0000_0000)
    else $error("blocked read returned data");
  AST_MEM_HIT: assert property (o_mem1_hit || o_mem2_hit |->
    $past(i_addr_valid && !i_addr_is_io && i_memory_enable))
    else $error("memory hit without cause");
  AST_IO_HIT: assert property (o_io_hit |-> $past(i_addr_valid && i_addr_is_io && i_io_enable))
    else $error("io hit without cause");
endmodule

bind window_base_regs window_base_regs_asserts i_window_base_regs_asserts (.*);

// file: verification/pci_host_model.sv
// Behavioural PCI host issuing configuration reads and writes
`timescale 1ns/100ps
module pci_host_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_cfg_rdata,
  input  wire logic        i_cfg_rvalid,
  output logic             o_cfg_write,
  output logic             o_cfg_read,
  output logic [7:0]       o_cfg_offset,
  output logic [31:0]      o_cfg_wdata,
  output logic [3:0]       o_cfg_byte_en
);
  // Idle bus at time zero
  initial begin
    o_cfg_write = 1'b0;
    o_cfg_read = 1'b0;
    o_cfg_offset = 8'h00;
    o_cfg_wdata = 32'h0000_0000;
    o_cfg_byte_en = 4'h0;
  end
  // One write pulse, none at all for offset 0x1c; released data flips so stale values never look valid
  task automatic wr(input logic [7:0] off, input logic [31:0] d, input logic [3:0] be);
    if (off != 8'h1c) begin
      @(negedge i_clk);
      o_cfg_write = 1'b1;
      o_cfg_offset = off;
      o_cfg_wdata = d;
      o_cfg_byte_en = be;
      @(negedge i_clk);
      o_cfg_write = 1'b0;
      o_cfg_wdata = ~d;
      o_cfg_byte_en = ~be;
    end
  endtask
  // One read pulse; answer is due exactly one cycle later
  task automatic rd(input logic [7:0] off, output logic ok, output logic [31:0] d);
    @(negedge i_clk);
    o_cfg_read = 1'b1;
    o_cfg_offset = off;
    @(negedge i_clk);
    o_cfg_read = 1'b0;
    ok = i_cfg_rvalid;
    d = i_cfg_rdata;
  endtask
endmodule

// file: verification/tb_window_base_regs.sv
// Self-checking bench for the window base registers
`timescale 1ns/100ps
module tb_window_base_regs;
  import window_base_pkg::*;
  typedef struct packed {logic [7:0] off; logic [31:0] wd; logic [3:0] be; logic [31:0] exp;} row_type;
  typedef struct packed {logic [31:0] a; logic io; logic me; logic ie; logic [2:0] exp;} dec_type;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic i_clk, i_reset, i_cfg_write, i_cfg_read, o_cfg_rvalid, i_int_write, i_int_read;
  logic o_int_rvalid, o_int_blocked, i_agent_mode, i_eeprom_load, i_memory_enable, i_io_enable;
  logic i_addr_valid, i_addr_is_io, o_mem1_hit, o_mem2_hit, o_io_hit, ok;
  logic [7:0]  i_cfg_offset;
  logic [3:0]  i_cfg_byte_en, i_int_byte_en;
  logic [15:0] i_int_addr;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, i_int_wdata, o_int_rdata, i_eeprom_data, i_addr;
  logic [31:0] o_mem1_base, o_mem2_base, o_io_base, d;
  int          n_fail = 0;
  int          cmp_count = 0;
  // Rows run in order: later rows rely on earlier writes
  row_type rows [8] = '{'{8'h18, 32'hFFFF_FFFF, 4'hF, 32'hFF00_0008}, '{8'h18, 32'h0000_0000, 4'h7, 32'hFF00_0008},
    '{8'h20, 32'hFFFF_FFFF, 4'hF, 32'hFFF0_0000}, '{8'h20, 32'h0000_0000, 4'hB, 32'h00F0_0000},
    '{8'h24, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FF01}, '{8'h24, 32'h0000_0000, 4'hE, 32'h0000_0001},
    '{8'h2c, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000}, '{8'h30, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000}};
  // Bases now mem1 0xFF, mem2 0x00F, io 0x000000
  dec_type decs [8] = '{'{32'hFF12_3456, 1'b0, 1'b1, 1'b1, 3'h4}, '{32'hFE12_3456, 1'b0, 1'b1, 1'b1, 3'h0},
    '{32'hFF12_3456, 1'b0, 1'b0, 1'b1, 3'h0}, '{32'hFF12_3456, 1'b1, 1'b1, 1'b1, 3'h0},
    '{32'h00F1_2345, 1'b0, 1'b1, 1'b1, 3'h2}, '{32'h0000_0042, 1'b1, 1'b1, 1'b1, 3'h1},
    '{32'h0000_0042, 1'b1, 1'b1, 1'b0, 3'h0}, '{32'h0000_0142, 1'b1, 1'b1, 1'b1, 3'h0}};
  window_base_regs i_window_base_regs (.*);
  pci_host_model i_pci_host_model (.i_clk(i_clk), .i_cfg_rdata(o_cfg_rdata), .i_cfg_rvalid(o_cfg_rvalid),
    .o_cfg_write(i_cfg_write), .o_cfg_read(i_cfg_read), .o_cfg_offset(i_cfg_offset),
    .o_cfg_wdata(i_cfg_wdata), .o_cfg_byte_en(i_cfg_byte_en));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch at %0t got %h exp %h", $time, g, e);
      n_fail++;
    end
  endtask
  // Missing answer turns into a guaranteed mismatch
  task automatic cfg_chk(input logic [7:0] off, input logic [31:0] e);
    i_pci_host_model.rd(off, ok, d);
    chk((ok === 1'b1) ? d : ~e, e);
  endtask
  task automatic iacc(input logic w, input logic [15:0] a, input logic [31:0] wd);
    @(negedge i_clk);
    i_int_write = w;
    i_int_read = !w;
    i_int_addr = a;
    i_int_wdata = wd;
    @(negedge i_clk);
    i_int_write = 1'b0;
    i_int_read = 1'b0;
    i_int_wdata = ~wd;
  endtask
  task automatic reset_values;
    cfg_chk(8'h18, 32'h0000_0008);
    cfg_chk(8'h1c, 32'h0000_0000);
    cfg_chk(8'h20, 32'h0000_0000);
    cfg_chk(8'h24, 32'h0000_0001);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Hang guard well past the expected run length
  initial begin
    #200us;
    n_fail++;
    complete_run();
  end
  initial begin
    {i_reset, i_int_write, i_int_read, i_agent_mode, i_eeprom_load} = 5'h10;
    {i_memory_enable, i_io_enable, i_addr_valid, i_addr_is_io} = 4'h0;
    {i_int_addr, i_int_byte_en, i_int_wdata, i_eeprom_data, i_addr} = '0;
    repeat (6) @(negedge i_clk);
    i_reset = 1'b0;
    i_int_byte_en = 4'hF;
    reset_values();
    cfg_chk(8'h2c, 32'h0000_0000);
    $display("test reset done");
    foreach (rows[i]) begin
      i_pci_host_model.wr(rows[i].off, rows[i].wd, rows[i].be);
      cfg_chk(rows[i].off, rows[i].exp);
    end
    chk(o_mem1_base, 32'hFF00_0008);
    chk(o_mem2_base, 32'h00F0_0000);
    chk(o_io_base, 32'h0000_0001);
    $display("test table done");
    foreach (decs[i]) begin
      @(negedge i_clk);
      {i_addr, i_addr_is_io, i_memory_enable, i_io_enable} = {decs[i].a, decs[i].io, decs[i].me, decs[i].ie};
      i_addr_valid = 1'b1;
      @(negedge i_clk);
      i_addr_valid = 1'b0;
      i_addr = ~decs[i].a;
      chk({29'h0, o_mem1_hit, o_mem2_hit, o_io_hit}, {29'h0, decs[i].exp});
    end
    $display("test decode done");
    i_agent_mode = 1'b1;
    iacc(1'b1, 16'hd020, 32'hFFFF_FFFF);
    chk({31'h0, o_int_blocked}, 32'h0000_0001);
    iacc(1'b0, 16'hd018, 32'h0000_0000);
    chk(o_int_rdata, 32'h0000_0000);
    i_agent_mode = 1'b0;
    cfg_chk(8'h20, 32'h00F0_0000);
    iacc(1'b1, 16'hd020, 32'hABCD_EF12);
    cfg_chk(8'h20, 32'hABC0_0000);
    iacc(1'b0, 16'hd024, 32'h0000_0000);
    chk({o_int_rdata[31:1], o_int_rvalid}, 32'h0000_0001);
    chk(o_int_rdata, 32'h0000_0001);
    chk({31'h0, o_int_blocked}, 32'h0000_0000);
    iacc(1'b0, 16'hd018, 32'h0000_0000);
    chk(o_int_rdata, 32'hFF00_0008);
    $display("test internal done");
    @(negedge i_clk);
    i_eeprom_load = 1'b1;
    i_eeprom_data = 32'hA5A5_5A5A;
    @(negedge i_clk);
    i_eeprom_load = 1'b0;
    i_eeprom_data = 32'h5A5A_A5A5;
    cfg_chk(8'h2c, 32'hA5A5_5A5A);
    i_pci_host_model.wr(8'h2c, 32'h0000_0000, 4'hF);
    iacc(1'b1, 16'hd02c, 32'h0000_0000);
    iacc(1'b0, 16'hd02c, 32'h0000_0000);
    chk(o_int_rdata, 32'hA5A5_5A5A);
    $display("test eeprom done");
    @(negedge i_clk);
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    reset_values();
    $display("test mid reset done");
    complete_run();
  end
endmodule
